// *** core/uart_ctrl_defines.vh ***
`ifndef UART_CTRL_DEFINES_VH
`define UART_CTRL_DEFINES_VH

// ********************************************************
// Register map (printed offsets, plain register port)
// ********************************************************
`define ADDR_W          12
`define OFS_DATA        12'hf40
`define OFS_STAT0       12'hf41
`define OFS_CTL_A       12'hf42
`define OFS_CTL_B       12'hf43
`define OFS_STAT1       12'hf44
`define OFS_CMP_ADDR    12'hf45
`define OFS_DIV_HI      12'hf46
`define OFS_DIV_LO      12'hf47

// ********************************************************
// serial_line_control_a fields
// ********************************************************
`define CA_TX_ON        7
`define CA_RX_ON        6
`define CA_CTS_GATE     5
`define CA_PARITY_ON    4
`define CA_PARITY_ODD   3
`define CA_BREAK        2
`define CA_TWO_STOP     1
`define CA_LOOPBACK     0

// ********************************************************
// serial_line_control_b fields
// ********************************************************
`define CB_MODE_HI      7
`define CB_NINE_BIT     6
`define CB_MODE_LO      5
`define CB_TX_NINTH     4
`define CB_DE_POL       3
`define CB_DIV_CTL      2
`define CB_RX_IRQ_MASK  1
`define CB_IR_ON        0

// ********************************************************
// Status fields
// ********************************************************
`define S1_NEW_FRAME    1
`define S1_RX_NINTH     0
`define S1_RESERVED     6'h00

// ********************************************************
// Reset values and constants
// ********************************************************
`define RST_BYTE        8'h00
`define RST_DIV_BYTE    8'hff
`define BYTE_ZERO       8'h00
`define DIV_ZERO        16'h0000
`define DIV_ONE         16'h0001
`define DIV_STEP        16'h0001
`define TICK_ZERO       4'h0
`define TICK_STEP       4'h1
`define TICK_LAST       4'hf
`define TICK_MID        4'h7
`define IR_PULSE_FIRST  4'h7
`define IR_PULSE_LAST   4'h9
`define BIT_ZERO        3'h0
`define BIT_STEP        3'h1
`define BIT_LAST        3'h7

// ********************************************************
// Address filter modes
// ********************************************************
`define MODE_ALL        2'h0
`define MODE_ADDR_ONLY  2'h1
`define MODE_MATCH_ALL  2'h2
`define MODE_MATCH_DATA 2'h3

`endif

// *** core/uart_ctrl_status_regs.v ***
`timescale 1ns/100ps
`default_nettype none
`include "uart_ctrl_defines.vh"

module uart_ctrl_status_regs (
	// Clock and reset
	input  wire                sys_clk,
	input  wire                nrst,
	// Register port
	input  wire [`ADDR_W-1:0]  reg_addr,
	input  wire [7:0]          reg_wdata,
	input  wire                reg_wr,
	input  wire                reg_rd,
	output reg  [7:0]          reg_rdata,
	// Serial pins
	input  wire                rxd_pin,
	input  wire                cts_n_pin,
	output reg                 txd_pin,
	output reg                 drv_en,
	// Requests to the interrupt controller
	output reg                 rx_irq,
	output reg                 timer_irq
);

	// ********************************************************
	// Decoding helpers
	// ********************************************************
	function hit;
		input [`ADDR_W-1:0] addr;
		input [`ADDR_W-1:0] ofs;
		begin
			hit = (addr == ofs);
		end
	endfunction

	function ir_pulse;
		input [3:0] ph;
		begin
			ir_pulse = (ph >= `IR_PULSE_FIRST) && (ph <= `IR_PULSE_LAST);
		end
	endfunction

	// ********************************************************
	// Registers
	// ********************************************************
	reg  [7:0]  serial_line_control_a;
	reg  [7:0]  serial_line_control_b;
	reg  [7:0]  cmp_addr;
	reg  [7:0]  div_hi;
	reg  [7:0]  div_lo;
	reg  [7:0]  tx_hold;
	reg         tx_empty;
	reg  [7:0]  rx_buf;
	reg         rx_avail;
	reg         parity_flag;
	reg         overrun_flag;
	reg         framing_flag;
	reg         break_flag;
	reg         first_byte_of_frame_flag;
	reg         received_ninth_bit;
	reg         addr_matched;
	reg         after_addr;
	reg  [15:0] div_cnt;
	reg         tick;
	reg         rxd_meta;
	reg         rxd_sync;
	reg         cts_meta;
	reg         cts_sync;
	reg  [3:0]  ir_hold;

	wire tx_on                  = serial_line_control_a[`CA_TX_ON];
	wire rx_on                  = serial_line_control_a[`CA_RX_ON];
	wire clear_to_send_gating   = serial_line_control_a[`CA_CTS_GATE];
	wire parity_on              = serial_line_control_a[`CA_PARITY_ON];
	wire parity_odd             = serial_line_control_a[`CA_PARITY_ODD];
	wire force_break            = serial_line_control_a[`CA_BREAK];
	wire two_stop               = serial_line_control_a[`CA_TWO_STOP];
	wire loopback_on            = serial_line_control_a[`CA_LOOPBACK];
	wire nine_bit_mode_on       = serial_line_control_b[`CB_NINE_BIT];
	wire tx_ninth_bit           = serial_line_control_b[`CB_TX_NINTH];
	wire driver_enable_polarity = serial_line_control_b[`CB_DE_POL];
	wire divider_timer_control  = serial_line_control_b[`CB_DIV_CTL];
	wire rx_data_irq_mask       = serial_line_control_b[`CB_RX_IRQ_MASK];
	wire infrared_path_on       = serial_line_control_b[`CB_IR_ON];
	wire [1:0] address_filter_mode = {serial_line_control_b[`CB_MODE_HI],
		serial_line_control_b[`CB_MODE_LO]};

	wire [15:0] div_reload = {div_hi, div_lo};
	wire        wr_data    = reg_wr && hit(reg_addr, `OFS_DATA);
	wire        rd_data    = reg_rd && hit(reg_addr, `OFS_DATA);

	// ********************************************************
	// Pin synchronisers
	// ********************************************************
	always @(posedge sys_clk) begin
		if (!nrst) begin
			rxd_meta <= 1'b1;
			rxd_sync <= 1'b1;
			cts_meta <= 1'b1;
			cts_sync <= 1'b1;
		end else begin
			rxd_meta <= rxd_pin;
			rxd_sync <= rxd_meta;
			cts_meta <= cts_n_pin;
			cts_sync <= cts_meta;
		end
	end

	// ********************************************************
	// Divider: sixteen ticks per bit, or a plain timer
	// ********************************************************
	always @(posedge sys_clk) begin
		if (!nrst) begin
			div_cnt   <= {`RST_DIV_BYTE, `RST_DIV_BYTE};
			tick      <= 1'b0;
			timer_irq <= 1'b0;
		end else begin
			// A divisor of zero or one ticks every cycle
			if (div_cnt <= `DIV_ONE) begin
				div_cnt <= div_reload;
				tick    <= 1'b1;
			end else begin
				div_cnt <= div_cnt - `DIV_STEP;
				tick    <= 1'b0;
			end
			timer_irq <= ~rx_on & divider_timer_control &
				(div_cnt <= `DIV_ONE);
		end
	end

	// ********************************************************
	// Transmit path
	// ********************************************************
	wire       tx_line;
	wire       tx_busy;
	wire [3:0] tx_phase;
	wire       tx_go    = tx_on & (~clear_to_send_gating | ~cts_sync);
	wire       tx_start = tx_go & ~tx_empty & ~tx_busy;

	uart_tx_shift u_tx (
		.sys_clk    (sys_clk),
		.nrst       (nrst),
		.tick       (tick),
		.start      (tx_start),
		.data       (tx_hold),
		.ninth_on   (nine_bit_mode_on),
		.ninth_val  (tx_ninth_bit),
		.parity_on  (parity_on),
		.parity_odd (parity_odd),
		.two_stop   (two_stop),
		.line       (tx_line),
		.busy       (tx_busy),
		.phase      (tx_phase)
	);

	// Infrared: a short high pulse in the middle of each zero bit
	wire tx_coded = infrared_path_on ?
		(~tx_line & ir_pulse(tx_phase)) : tx_line;

	always @(posedge sys_clk) begin
		if (!nrst) begin
			txd_pin <= 1'b1;
			drv_en  <= 1'b0;
		end else begin
			// Break cuts off whatever is being shifted
			txd_pin <= force_break ? 1'b0 : tx_coded;
			drv_en  <= tx_busy ^ driver_enable_polarity;
		end
	end

	always @(posedge sys_clk) begin
		if (!nrst) begin
			tx_hold  <= `RST_BYTE;
			tx_empty <= 1'b1;
		end else begin
			if (tx_start) begin
				tx_empty <= 1'b1;
			end
			// A write in the same cycle as a take refills the holder
			if (wr_data) begin
				tx_hold  <= reg_wdata;
				tx_empty <= 1'b0;
			end
		end
	end

	// ********************************************************
	// Receive path
	// ********************************************************
	// Loopback takes the pin level so it passes the same coder
	wire rx_raw = loopback_on ? txd_pin : rxd_sync;

	// Infrared decoder stretches each pulse into a full zero bit
	always @(posedge sys_clk) begin
		if (!nrst) begin
			ir_hold <= `TICK_ZERO;
		end else if (rx_raw) begin
			ir_hold <= `TICK_LAST;
		end else if (tick && ir_hold != `TICK_ZERO) begin
			ir_hold <= ir_hold - `TICK_STEP;
		end
	end

	wire rx_line = infrared_path_on ?
		~(rx_raw | (ir_hold != `TICK_ZERO)) : rx_raw;

	wire       rx_done;
	wire [7:0] rx_data;
	wire       rx_ninth;
	wire       rx_perr;
	wire       rx_ferr;
	wire       rx_brk;

	uart_rx_shift u_rx (
		.sys_clk    (sys_clk),
		.nrst       (nrst),
		.tick       (tick),
		.enable     (rx_on),
		.line       (rx_line),
		.ninth_on   (nine_bit_mode_on),
		.parity_on  (parity_on),
		.parity_odd (parity_odd),
		.done       (rx_done),
		.data       (rx_data),
		.ninth      (rx_ninth),
		.parity_err (rx_perr),
		.frame_err  (rx_ferr),
		.break_seen (rx_brk)
	);

	// ********************************************************
	// Address filtering
	// ********************************************************
	wire is_addr = nine_bit_mode_on & rx_ninth;
	wire match   = (rx_data == cmp_addr);
	reg  accept;
	reg  irq_ok;

	always @* begin
		accept = 1'b1;
		irq_ok = 1'b1;
		if (nine_bit_mode_on) begin
			case (address_filter_mode)
			`MODE_ALL: begin
				accept = 1'b1;
				irq_ok = 1'b1;
			end
			`MODE_ADDR_ONLY: begin
				accept = 1'b1;
				irq_ok = is_addr;
			end
			`MODE_MATCH_ALL: begin
				accept = is_addr ? match : addr_matched;
				irq_ok = accept;
			end
			`MODE_MATCH_DATA: begin
				accept = ~is_addr & addr_matched;
				irq_ok = accept;
			end
			default: begin
				accept = 1'b1;
				irq_ok = 1'b1;
			end
			endcase
		end
	end

	wire take    = rx_done & accept;
	wire rx_errs = rx_perr | rx_ferr | rx_brk | rx_avail;

	// ********************************************************
	// Receive status
	// ********************************************************
	always @(posedge sys_clk) begin
		if (!nrst) begin
			rx_buf                   <= `RST_BYTE;
			rx_avail                 <= 1'b0;
			parity_flag              <= 1'b0;
			overrun_flag             <= 1'b0;
			framing_flag             <= 1'b0;
			break_flag               <= 1'b0;
			first_byte_of_frame_flag <= 1'b0;
			received_ninth_bit       <= 1'b0;
			addr_matched             <= 1'b0;
			after_addr               <= 1'b0;
			rx_irq                   <= 1'b0;
		end else begin
			if (rd_data) begin
				rx_avail                 <= 1'b0;
				parity_flag              <= 1'b0;
				overrun_flag             <= 1'b0;
				framing_flag             <= 1'b0;
				break_flag               <= 1'b0;
				first_byte_of_frame_flag <= 1'b0;
				received_ninth_bit       <= 1'b0;
			end
			if (rx_done && is_addr) begin
				addr_matched <= match;
				after_addr   <= 1'b1;
			end else if (rx_done) begin
				after_addr <= 1'b0;
			end
			// A new byte wins over a read in the same cycle
			if (take) begin
				rx_buf                   <= rx_data;
				rx_avail                 <= 1'b1;
				parity_flag              <= rx_perr;
				overrun_flag             <= rx_avail;
				framing_flag             <= rx_ferr;
				break_flag               <= rx_brk;
				first_byte_of_frame_flag <= ~is_addr & after_addr;
				received_ninth_bit       <= rx_ninth;
			end
			rx_irq <= take & ((irq_ok & ~rx_data_irq_mask) | rx_errs);
		end
	end

	// ********************************************************
	// Register writes
	// ********************************************************
	// Fields act at once; safe reconfiguration is up to software
	always @(posedge sys_clk) begin
		if (!nrst) begin
			serial_line_control_a <= `RST_BYTE;
			serial_line_control_b <= `RST_BYTE;
			cmp_addr              <= `RST_BYTE;
			div_hi                <= `RST_DIV_BYTE;
			div_lo                <= `RST_DIV_BYTE;
		end else if (reg_wr) begin
			case (reg_addr)
			`OFS_CTL_A:    serial_line_control_a <= reg_wdata;
			`OFS_CTL_B:    serial_line_control_b <= reg_wdata;
			`OFS_CMP_ADDR: cmp_addr              <= reg_wdata;
			`OFS_DIV_HI:   div_hi                <= reg_wdata;
			`OFS_DIV_LO:   div_lo                <= reg_wdata;
			// Status writes store nothing; reserved bits expected zero
			default:       cmp_addr              <= cmp_addr;
			endcase
		end
	end

	// ********************************************************
	// Register reads, one cycle after the strobe
	// ********************************************************
	wire [15:0] div_view = divider_timer_control ? div_cnt : div_reload;

	always @(posedge sys_clk) begin
		if (!nrst) begin
			reg_rdata <= `BYTE_ZERO;
		end else if (reg_rd) begin
			case (reg_addr)
			`OFS_DATA:     reg_rdata <= rx_buf;
			`OFS_STAT0:    reg_rdata <= {rx_avail, parity_flag,
				overrun_flag, framing_flag, break_flag, tx_empty,
				tx_empty & ~tx_busy, cts_sync};
			`OFS_CTL_A:    reg_rdata <= serial_line_control_a;
			`OFS_CTL_B:    reg_rdata <= serial_line_control_b;
			`OFS_STAT1:    reg_rdata <= {`S1_RESERVED,
				first_byte_of_frame_flag, received_ninth_bit};
			`OFS_CMP_ADDR: reg_rdata <= cmp_addr;
			`OFS_DIV_HI:   reg_rdata <= div_view[15:8];
			`OFS_DIV_LO:   reg_rdata <= div_view[7:0];
			default:       reg_rdata <= `BYTE_ZERO;
			endcase
		end else begin
			reg_rdata <= `BYTE_ZERO;
		end
	end

endmodule
`default_nettype wire

// *** core/uart_rx_shift.v ***
`timescale 1ns/100ps
`default_nettype none
`include "uart_ctrl_defines.vh"

module uart_rx_shift (
	// Clock and reset
	input  wire       sys_clk,
	input  wire       nrst,
	// Oversample tick and enable
	input  wire       tick,
	input  wire       enable,
	// Decoded serial line
	input  wire       line,
	// Frame format
	input  wire       ninth_on,
	input  wire       parity_on,
	input  wire       parity_odd,
	// Received character
	output reg        done,
	output reg  [7:0] data,
	output reg        ninth,
	output reg        parity_err,
	output reg        frame_err,
	output reg        break_seen
);

	localparam IDLE  = 3'h0;
	localparam START = 3'h1;
	localparam DATA  = 3'h2;
	localparam EXTRA = 3'h3;
	localparam STOP  = 3'h4;

	reg [2:0] state;
	reg [3:0] tick_cnt;
	reg [2:0] bit_cnt;
	reg [7:0] shreg;
	reg       extra_bit;

	wire has_extra = ninth_on | parity_on;
	wire sample    = tick && (tick_cnt == `TICK_LAST);

	always @(posedge sys_clk) begin
		if (!nrst) begin
			state      <= IDLE;
			tick_cnt   <= `TICK_ZERO;
			bit_cnt    <= `BIT_ZERO;
			shreg      <= `BYTE_ZERO;
			extra_bit  <= 1'b0;
			done       <= 1'b0;
			data       <= `BYTE_ZERO;
			ninth      <= 1'b0;
			parity_err <= 1'b0;
			frame_err  <= 1'b0;
			break_seen <= 1'b0;
		end else begin
			done <= 1'b0;
			if (!enable) begin
				state <= IDLE;
			end else begin
				if (tick && state != IDLE) begin
					tick_cnt <= (state == START && tick_cnt == `TICK_MID) ?
						`TICK_ZERO : tick_cnt + `TICK_STEP;
				end
				case (state)
				IDLE: begin
					tick_cnt <= `TICK_ZERO;
					if (!line) begin
						state <= START;
					end
				end
				START: begin
					// Glitch shorter than half a bit is dropped
					if (tick && tick_cnt == `TICK_MID) begin
						bit_cnt   <= `BIT_ZERO;
						extra_bit <= 1'b0;
						state     <= line ? IDLE : DATA;
					end
				end
				DATA: begin
					if (sample) begin
						shreg   <= {line, shreg[7:1]};
						bit_cnt <= bit_cnt + `BIT_STEP;
						if (bit_cnt == `BIT_LAST) begin
							state <= has_extra ? EXTRA : STOP;
						end
					end
				end
				EXTRA: begin
					if (sample) begin
						extra_bit <= line;
						state     <= STOP;
					end
				end
				STOP: begin
					if (sample) begin
						done       <= 1'b1;
						data       <= shreg;
						ninth      <= ninth_on & extra_bit;
						parity_err <= parity_on & ~ninth_on &
							(extra_bit != (parity_odd ^ (^shreg)));
						frame_err  <= ~line;
						break_seen <= ~line & ~extra_bit &
							(shreg == `BYTE_ZERO);
						state      <= IDLE;
					end
				end
				default: begin
					state <= IDLE;
				end
				endcase
			end
		end
	end

endmodule
`default_nettype wire

// *** core/uart_tx_shift.v ***
`timescale 1ns/100ps
`default_nettype none
`include "uart_ctrl_defines.vh"

module uart_tx_shift (
	// Clock and reset
	input  wire       sys_clk,
	input  wire       nrst,
	// Oversample tick, sixteen per bit
	input  wire       tick,
	// Character request
	input  wire       start,
	input  wire [7:0] data,
	// Frame format
	input  wire       ninth_on,
	input  wire       ninth_val,
	input  wire       parity_on,
	input  wire       parity_odd,
	input  wire       two_stop,
	// Line side
	output reg        line,
	output wire       busy,
	output wire [3:0] phase
);

	localparam IDLE  = 3'h0;
	localparam START = 3'h1;
	localparam DATA  = 3'h2;
	localparam EXTRA = 3'h3;
	localparam STOP  = 3'h4;

	reg [2:0] state;
	reg [3:0] tick_cnt;
	reg [2:0] bit_cnt;
	reg [7:0] shreg;
	reg       extra_bit;
	reg       has_extra;
	reg       stop_left;

	assign busy  = (state != IDLE);
	assign phase = tick_cnt;

	always @(posedge sys_clk) begin
		if (!nrst) begin
			state     <= IDLE;
			tick_cnt  <= `TICK_ZERO;
			bit_cnt   <= `BIT_ZERO;
			shreg     <= `BYTE_ZERO;
			extra_bit <= 1'b0;
			has_extra <= 1'b0;
			stop_left <= 1'b0;
			line      <= 1'b1;
		end else if (state == IDLE) begin
			line <= 1'b1;
			if (start) begin
				shreg     <= data;
				// Ninth bit takes the parity slot when both are on
				extra_bit <= ninth_on ? ninth_val : (parity_odd ^ (^data));
				has_extra <= ninth_on | parity_on;
				stop_left <= two_stop;
				tick_cnt  <= `TICK_ZERO;
				line      <= 1'b0;
				state     <= START;
			end
		end else if (tick) begin
			if (tick_cnt != `TICK_LAST) begin
				tick_cnt <= tick_cnt + `TICK_STEP;
			end else begin
				tick_cnt <= `TICK_ZERO;
				case (state)
				START: begin
					line    <= shreg[0];
					bit_cnt <= `BIT_ZERO;
					state   <= DATA;
				end
				DATA: begin
					if (bit_cnt == `BIT_LAST) begin
						line  <= has_extra ? extra_bit : 1'b1;
						state <= has_extra ? EXTRA : STOP;
					end else begin
						line    <= shreg[1];
						shreg   <= {1'b0, shreg[7:1]};
						bit_cnt <= bit_cnt + `BIT_STEP;
					end
				end
				EXTRA: begin
					line  <= 1'b1;
					state <= STOP;
				end
				STOP: begin
					if (stop_left) begin
						stop_left <= 1'b0;
					end else begin
						state <= IDLE;
					end
				end
				default: begin
					state <= IDLE;
				end
				endcase
			end
		end
	end

endmodule
`default_nettype wire

// *** tb/serial_node_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module serial_node_model #(
	parameter int BIT_CYC = 16
) (
	// Clock
	input  wire logic sys_clk,
	// Line towards the device
	output var logic  line
);
	// Pulled up: idle and released both read high
	initial line = 1'b1;
	task automatic send(input logic [7:0] d, input logic adr);
		logic [10:0] f;
		f = {2'b11, adr, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			line <= f[i];
			repeat (BIT_CYC) @(posedge sys_clk);
		end
	endtask
endmodule
`default_nettype wire

// *** tb/tb_uart_ctrl_status_regs.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "uart_ctrl_defines.vh"
module tb_uart_ctrl_status_regs;
	logic               sys_clk, nrst, reg_wr, reg_rd, cts_n_pin;
	logic [`ADDR_W-1:0] reg_addr;
	logic [7:0]         reg_wdata, rd_val, lfsr, adr, dv;
	wire logic [7:0]    reg_rdata;
	wire logic          rxd_pin, txd_pin, drv_en, rx_irq, timer_irq;
	int                 fail_count, num_checks, irq_n, n;
	logic [7:0]         ta [5] = '{8'h80, 8'h98, 8'h92, 8'hb0, 8'ha0};
	logic [7:0]         tb [5] = '{8'h00, 8'h00, 8'h00, 8'h48, 8'h58};
	logic [7:0]         mb [5] = '{8'h40, 8'h60, 8'hc0, 8'he0, 8'h42};
	logic [3:0]         me [5] = '{4'hf, 4'h5, 4'h3, 4'h2, 4'h0};
	uart_ctrl_status_regs dut (.sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .rxd_pin, .cts_n_pin, .txd_pin, .drv_en, .rx_irq,
		.timer_irq);
	serial_node_model #(.BIT_CYC(16)) node (.sys_clk, .line(rxd_pin));
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
		if (rx_irq === 1'b1)
			irq_n <= irq_n + 1;
	function automatic logic [7:0] nxt(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic end_of_test;
		if (fail_count == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// ****
	// Register port: strobes stay up between calls, idle drops them
	// ****
	task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		#1 rd_val = reg_rdata;
	endtask
	task automatic idle;
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(rd_val, e);
	endtask
	task automatic txf(input logic [7:0] a, input logic [7:0] b, input logic [7:0] d);
		logic [11:0] f;
		int len;
		bus(1'b1, `OFS_CTL_B, b);
		bus(1'b1, `OFS_CTL_A, a);
		bus(1'b1, `OFS_DATA, d);
		idle();
		if (a[5]) begin
			repeat (40) @(posedge sys_clk);
			chk(8'(txd_pin), 8'h01);
			cts_n_pin <= 1'b0;
		end
		n = 0;
		while (txd_pin !== 1'b0 && n < 50) begin
			@(negedge sys_clk);
			n++;
		end
		chk(8'(n < 50), 8'h01);
		if (n == 50)
			end_of_test();
		repeat (8) @(negedge sys_clk);
		// Twelve bits so a second stop after the extra bit reads high
		f = b[6] ? {3'b111, b[4], d, 1'b0} :
			a[4] ? {3'b111, ^d ^ a[3], d, 1'b0} :
			{4'b1111, d, 1'b0};
		len = 10 + int'(b[6] | a[4]) + int'(a[1]);
		for (int k = 0; k <= len; k++) begin
			if (k < len)
				chk(8'(txd_pin), 8'(f[k]));
			chk(8'(drv_en), 8'((k < len) ^ b[3]));
			repeat (16) @(negedge sys_clk);
		end
		@(posedge sys_clk);
		cts_n_pin <= 1'b1;
		bus(1'b1, `OFS_CTL_A, 8'h00);
		idle();
	endtask
	initial begin
		{nrst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		{fail_count, num_checks, irq_n} = '0;
		cts_n_pin = 1'b1;
		lfsr = 8'h53;
		repeat (6) @(posedge sys_clk);
		nrst <= 1'b1;
		for (int i = 2; i < 5; i++)
			rdc(`OFS_DATA + 12'(i), 8'h00);
		bus(1'b1, `OFS_STAT1, 8'h00);
		bus(1'b1, 12'h0a5, 8'hff);
		rdc(12'h0a5, 8'h00);
		repeat (4) begin
			lfsr = nxt(lfsr);
			bus(1'b1, `OFS_CTL_A, lfsr & 8'h3b);
			rdc(`OFS_CTL_A, lfsr & 8'h3b);
			bus(1'b1, `OFS_CTL_B, lfsr & 8'h7a);
			rdc(`OFS_CTL_B, lfsr & 8'h7a);
		end
		bus(1'b1, `OFS_CTL_A, 8'h00);
		bus(1'b1, `OFS_DIV_HI, 8'h00);
		bus(1'b1, `OFS_DIV_LO, 8'h01);
		bus(1'b1, `OFS_CTL_B, 8'h04);
		idle();
		// Counter still runs down from its reset value before the new divisor
		n = 0;
		while (timer_irq !== 1'b1 && n < 70000) begin
			@(posedge sys_clk);
			n++;
		end
		chk(8'(n < 70000), 8'h01);
		if (n == 70000)
			end_of_test();
		for (int i = 0; i < 5; i++) begin
			lfsr = nxt(lfsr);
			txf(ta[i], tb[i], lfsr);
		end
		bus(1'b1, `OFS_CTL_B, 8'h00);
		bus(1'b1, `OFS_CTL_A, 8'h84);
		idle();
		repeat (3) @(posedge sys_clk);
		chk(8'(txd_pin), 8'h00);
		// Plain loopback, then the same through the infrared coder
		for (int p = 0; p < 2; p++) begin
			bus(1'b1, `OFS_CTL_A, 8'h00);
			bus(1'b1, `OFS_CTL_B, 8'(p));
			bus(1'b1, `OFS_CTL_A, 8'h01);
			idle();
			// Lets the pulse stretcher drain before the receiver looks
			repeat (20) @(posedge sys_clk);
			irq_n = 0;
			bus(1'b1, `OFS_CTL_A, 8'hc1);
			bus(1'b1, `OFS_DATA, lfsr);
			idle();
			repeat (250) @(posedge sys_clk);
			chk(8'(irq_n), 8'h01);
			rdc(`OFS_DATA, lfsr);
		end
		adr = nxt(lfsr);
		bus(1'b1, `OFS_CTL_A, 8'h00);
		bus(1'b1, `OFS_CMP_ADDR, adr);
		for (int m = 0; m < 5; m++) begin
			bus(1'b1, `OFS_CTL_A, 8'h00);
			bus(1'b1, `OFS_CTL_B, mb[m]);
			bus(1'b1, `OFS_CTL_A, 8'h40);
			idle();
			for (int j = 0; j < 4; j++) begin
				lfsr = nxt(lfsr);
				dv = j[0] ? lfsr : adr ^ 8'(j[1]);
				irq_n = 0;
				node.send(dv, !j[0]);
				repeat (24) @(posedge sys_clk);
				chk(8'(irq_n), 8'(me[m][j]));
				if (m == 0) begin
					rdc(`OFS_STAT1, j[0] ? 8'h02 : 8'h01);
					rdc(`OFS_DATA, dv);
					rdc(`OFS_STAT1, 8'h00);
				end else
					bus(1'b0, `OFS_DATA, 8'h00);
				idle();
			end
		end
		end_of_test();
	end
endmodule
`default_nettype wire

// *** tb/uart_ctrl_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "uart_ctrl_defines.vh"
module uart_ctrl_monitor (
	// Clock and reset
	input wire logic               sys_clk,
	input wire logic               nrst,
	// Register port
	input wire logic [`ADDR_W-1:0] reg_addr,
	input wire logic [7:0]         reg_wdata,
	input wire logic               reg_wr,
	input wire logic               reg_rd,
	input wire logic [7:0]         reg_rdata,
	// Pins and requests
	input wire logic               rxd_pin,
	input wire logic               cts_n_pin,
	input wire logic               txd_pin,
	input wire logic               drv_en,
	input wire logic               rx_irq,
	input wire logic               timer_irq
);
	// ****
	// Shadow controls and age counters
	// ****
	logic [7:0] cta;
	logic [7:0] ctb;
	logic [7:0] idle_n;
	logic [7:0] cts_age;
	wire        busy = drv_en ^ ctb[3];
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			cta <= 8'h00;
			ctb <= 8'h00;
			idle_n <= 8'h00;
			cts_age <= 8'hff;
		end else begin
			if (reg_wr && reg_addr == `OFS_CTL_A)
				cta <= reg_wdata;
			if (reg_wr && reg_addr == `OFS_CTL_B)
				ctb <= reg_wdata;
			// Saturates past the longest frame, so idle is certain
			if (cta[7])
				idle_n <= 8'h00;
			else if (idle_n != 8'hff)
				idle_n <= idle_n + 8'h01;
			if (!cts_n_pin)
				cts_age <= 8'h00;
			else if (cts_age != 8'hff)
				cts_age <= cts_age + 8'h01;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	tx_start_a: assert property ($rose(busy) && $stable(ctb) |-> $past(cta[7]))
		else $error("transmit began while disabled");
	cts_gate_a: assert property ($rose(busy) && cta[5] |-> cts_age < 8'h08)
		else $error("transmit began with clear-to-send high");
	tx_idle_a: assert property (idle_n == 8'hff && !cta[2] && !ctb[0] && $stable(cta) && $stable(ctb) |-> txd_pin)
		else $error("idle line not high");
	break_low_a: assert property (cta[2] && $past(cta[2]) && !ctb[0] |-> !txd_pin)
		else $error("line not low in break");
	drv_pol_a: assert property (idle_n == 8'hff && $stable(ctb) |-> drv_en == ctb[3])
		else $error("idle driver enable level wrong");
	rx_off_a: assert property ((!cta[6])[*4] |-> !rx_irq)
		else $error("request with receiver off");
	stat_resv_a: assert property (reg_rd && reg_addr == `OFS_STAT1 |=> reg_rdata[7:2] == 6'h00)
		else $error("reserved status bits set");
	rd_clear_a: assert property (reg_rd && reg_addr == `OFS_DATA ##1 reg_rd && reg_addr == `OFS_STAT1 && !rx_irq |=> reg_rdata == 8'h00)
		else $error("status not cleared by data read");
	cover property (rx_irq);
	cover property ($rose(busy) && cta[5]);
	cover property (cta[2] && !txd_pin);
endmodule
bind uart_ctrl_status_regs uart_ctrl_monitor mon (.sys_clk, .nrst, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rxd_pin, .cts_n_pin, .txd_pin,
	.drv_en, .rx_irq, .timer_irq);
`default_nettype wire
